// ---- hw/jtdr_top.sv ----
// test data registers: identification, bypass and boundary chain
`timescale 1ns/10ps
module jtdr_top #(
  parameter logic [3:0]  REVISION = 4'h0,
  parameter logic [15:0] DEV_CODE = 16'h0a5c, // arbitrary value
  parameter logic [10:0] MFR_CODE = 11'h123   // arbitrary value
) (
  // clock and reset
  input  wire logic                 CLOCK_IN,
  input  wire logic                 RST_B_IN,
  // test port pins
  input  wire logic                 TEST_CLOCK_PIN_IN,
  input  wire logic                 TEST_SERIAL_IN_IN,
  // tap controller state and current instruction
  input  wire jtdr_pkg::jtdr_ctl_t  TAP_CTL_IN,
  // device pins under boundary control
  input  wire logic                 CORE_DATA_IN,
  input  wire logic                 CORE_OE_B_IN,
  input  wire logic                 PAD_OBS_IN,
  output logic                      PAD_DATA_OUT,
  output logic                      PAD_OE_B_OUT,
  // serial result and latched id word
  output logic                      TEST_SERIAL_OUT_OUT,
  output logic [31:0]               ID_LATCH_OUT
);
  logic tck_rise, tck_fall;
  logic tdi_s1_ff, tdi_ff;
  logic pad_s1_ff, pad_ff;
  logic [31:0] id_shift_ff, id_latch_ff;
  logic        bypass_ff;
  logic [2:0]  bsr_shift_ff, bsr_latch_ff;
  logic        tdo_ff;
  logic [31:0] id_word;
  logic        sel_id, sel_bsr, sel_byp, test_mode;
  jtdr_pkg::jtdr_state_t st;
  logic [2:0]  ins;

  ////////////////////////////////////////////////////////////////////////
  // test clock edges
  jtdr_edge u_tck (
    .CLOCK_IN  (CLOCK_IN),
    .RST_B_IN  (RST_B_IN),
    .pin_in    (TEST_CLOCK_PIN_IN),
    .level_out (),
    .rise_out  (tck_rise),
    .fall_out  (tck_fall)
  );

  // serial input and observed pad synchronisers
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tdi_s1_ff <= 1'b0;
      tdi_ff    <= 1'b0;
      pad_s1_ff <= 1'b0;
      pad_ff    <= 1'b0;
    end else begin
      tdi_s1_ff <= TEST_SERIAL_IN_IN;
      tdi_ff    <= tdi_s1_ff;
      pad_s1_ff <= PAD_OBS_IN;
      pad_ff    <= pad_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // selection
  assign st = TAP_CTL_IN.state;
  assign ins = TAP_CTL_IN.instr;
  assign id_word = {REVISION, DEV_CODE, MFR_CODE, jtdr_pkg::ID_FIXED_ONE};
  assign sel_id  = (ins == jtdr_pkg::INSTR_IDENTIFY) || (st == jtdr_pkg::JTDR_TLR);
  assign sel_byp = !sel_id && ((ins == jtdr_pkg::INSTR_BYPASS) || (ins == jtdr_pkg::INSTR_CLAMP)
                   || (ins == jtdr_pkg::INSTR_FLOAT));
  assign sel_bsr = !sel_id && ((ins == jtdr_pkg::INSTR_SAMPLE) || (ins == jtdr_pkg::INSTR_EXTERNAL_TEST_INSTRUCTION));
  assign test_mode = (st != jtdr_pkg::JTDR_TLR) && ((ins == jtdr_pkg::INSTR_EXTERNAL_TEST_INSTRUCTION)
                     || (ins == jtdr_pkg::INSTR_CLAMP) || (ins == jtdr_pkg::INSTR_FLOAT));

  ////////////////////////////////////////////////////////////////////////
  // identification shift path and latch
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      id_shift_ff <= jtdr_pkg::ID_RESET;
    end else if (tck_rise && sel_id && st == jtdr_pkg::JTDR_CAPTURE) begin
      id_shift_ff <= id_word;
    end else if (tck_rise && sel_id && st == jtdr_pkg::JTDR_SHIFT) begin
      id_shift_ff <= {tdi_ff, id_shift_ff[31:1]};
    end
  end

  // latched id output, apart from the shift path
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      id_latch_ff <= jtdr_pkg::ID_RESET;
    end else if (st == jtdr_pkg::JTDR_TLR) begin
      id_latch_ff <= id_word; // forced during reset state
    end else if (tck_fall && sel_id && st == jtdr_pkg::JTDR_UPDATE) begin
      id_latch_ff <= id_shift_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bypass stage
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bypass_ff <= 1'b0;
    end else if (tck_rise && sel_byp && st == jtdr_pkg::JTDR_CAPTURE) begin
      bypass_ff <= 1'b0;
    end else if (tck_rise && sel_byp && st == jtdr_pkg::JTDR_SHIFT) begin
      bypass_ff <= tdi_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boundary chain shift path
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bsr_shift_ff <= jtdr_pkg::BSR_RESET;
    end else if (tck_rise && sel_bsr && st == jtdr_pkg::JTDR_CAPTURE) begin
      bsr_shift_ff <= {pad_ff, CORE_DATA_IN, ~CORE_OE_B_IN};
    end else if (tck_rise && sel_bsr && st == jtdr_pkg::JTDR_SHIFT) begin
      bsr_shift_ff <= {tdi_ff, bsr_shift_ff[2:1]};
    end
  end

  // boundary latch
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bsr_latch_ff <= jtdr_pkg::BSR_RESET;
    end else if (tck_fall && sel_bsr && st == jtdr_pkg::JTDR_UPDATE) begin
      bsr_latch_ff <= bsr_shift_ff;
    end
  end

  // pad drive: cell 0 enables output cell 1
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PAD_DATA_OUT <= 1'b0;
      PAD_OE_B_OUT <= 1'b1;
    end else if (test_mode && ins == jtdr_pkg::INSTR_FLOAT) begin
      PAD_DATA_OUT <= 1'b0;
      PAD_OE_B_OUT <= 1'b1;
    end else if (test_mode) begin
      PAD_DATA_OUT <= bsr_latch_ff[jtdr_pkg::BSR_OUT_IDX];
      PAD_OE_B_OUT <= ~bsr_latch_ff[jtdr_pkg::BSR_CTRL_IDX];
    end else begin
      PAD_DATA_OUT <= CORE_DATA_IN;
      PAD_OE_B_OUT <= CORE_OE_B_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output, changes on falling test clock
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tdo_ff <= 1'b0;
    end else if (tck_fall && st == jtdr_pkg::JTDR_SHIFT) begin
      if (sel_id) begin
        tdo_ff <= id_shift_ff[0];
      end else if (sel_bsr) begin
        tdo_ff <= bsr_shift_ff[0];
      end else begin
        tdo_ff <= bypass_ff;
      end
    end
  end
  assign TEST_SERIAL_OUT_OUT = tdo_ff;
  assign ID_LATCH_OUT = id_latch_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // sampled reset in the antecedent keeps the release edge, where the latch was still cleared, out
  id_format_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (RST_B_IN && st == jtdr_pkg::JTDR_TLR) |=> (id_latch_ff[0] == 1'b1))
    else $error("id bit zero not one");
  id_capture_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (tck_rise && ins == jtdr_pkg::INSTR_IDENTIFY && st == jtdr_pkg::JTDR_CAPTURE)
    |=> (id_shift_ff == id_word))
    else $error("id not captured");
  id_shift_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (tck_rise && sel_id && st == jtdr_pkg::JTDR_SHIFT)
    |=> (id_shift_ff[30:0] == $past(id_shift_ff[31:1])))
    else $error("id shift wrong");
  id_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (st != jtdr_pkg::JTDR_TLR && !(tck_fall && st == jtdr_pkg::JTDR_UPDATE))
    |=> $stable(id_latch_ff))
    else $error("id latch moved");
  tlr_select_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (st == jtdr_pkg::JTDR_TLR) |-> sel_id)
    else $error("id not selected in reset");
  bypass_path_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (tck_rise && sel_byp && st == jtdr_pkg::JTDR_SHIFT) |=> (bypass_ff == $past(tdi_ff)))
    else $error("bypass wrong");
  bsr_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    !sel_bsr |=> $stable(bsr_shift_ff))
    else $error("unselected chain moved");
  bsr_update_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (tck_fall && sel_bsr && st == jtdr_pkg::JTDR_UPDATE) |=> (bsr_latch_ff == $past(bsr_shift_ff)))
    else $error("chain latch missed");
  pad_ctrl_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    (test_mode && ins == jtdr_pkg::INSTR_EXTERNAL_TEST_INSTRUCTION) ##1 (test_mode && ins == jtdr_pkg::INSTR_EXTERNAL_TEST_INSTRUCTION)
    |-> (PAD_OE_B_OUT == ~$past(bsr_latch_ff[0])))
    else $error("pad enable not from cell 0");
  id_cap_c: cover property (@(posedge CLOCK_IN) tck_rise && sel_id && st == jtdr_pkg::JTDR_CAPTURE);
  byp_c: cover property (@(posedge CLOCK_IN) tck_rise && sel_byp && st == jtdr_pkg::JTDR_SHIFT);
  bsr_upd_c: cover property (@(posedge CLOCK_IN) tck_fall && sel_bsr && st == jtdr_pkg::JTDR_UPDATE);
endmodule : jtdr_top

// ---- hw/jtdr_pkg.sv ----
// package: constants and types for the boundary-scan test data registers
package jtdr_pkg;
  // instruction codes
  localparam logic [2:0] INSTR_SAMPLE   = 3'h2;
  localparam logic [2:0] INSTR_BYPASS   = 3'h7;
  localparam logic [2:0] INSTR_EXTERNAL_TEST_INSTRUCTION   = 3'h0;
  localparam logic [2:0] INSTR_CLAMP    = 3'h3;
  localparam logic [2:0] INSTR_FLOAT    = 3'h4;
  localparam logic [2:0] INSTR_IDENTIFY = 3'h1;
  // id word layout
  localparam int ID_WIDTH    = 32;
  localparam int ID_REV_LSB  = 28;
  localparam int ID_DEV_LSB  = 12;
  localparam int ID_MFR_LSB  = 1;
  localparam logic ID_FIXED_ONE = 1'b1;
  // boundary chain modelled: control cell 0 drives tristate output cell 1,
  // cell 2 is an observe-only input cell
  localparam int BSR_LEN      = 3;
  localparam int BSR_CTRL_IDX = 0;
  localparam int BSR_OUT_IDX  = 1;
  localparam int BSR_OBS_IDX  = 2;
  localparam logic [2:0] BSR_RESET = 3'h0;
  localparam logic [31:0] ID_RESET = 32'h0;
  // tap states seen by this block
  typedef enum logic [2:0] {
    JTDR_TLR, JTDR_IDLE, JTDR_CAPTURE, JTDR_SHIFT, JTDR_UPDATE, JTDR_OTHER
  } jtdr_state_t;
  // strobe bundle from the tap controller
  typedef struct packed {
    jtdr_state_t state;
    logic [2:0]  instr;
  } jtdr_ctl_t;
endpackage : jtdr_pkg

// ---- hw/jtdr_edge.sv ----
// edge finder for the sampled test clock
`timescale 1ns/10ps
module jtdr_edge (
  // clock and reset
  input  wire logic CLOCK_IN,
  input  wire logic RST_B_IN,
  // raw pin
  input  wire logic pin_in,
  // synchronised level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic s1_ff, s2_ff, s3_ff;
  // two-stage synchroniser then edge history
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign level_out = s2_ff;
  assign rise_out  = s2_ff & ~s3_ff;
  assign fall_out  = ~s2_ff & s3_ff;
endmodule : jtdr_edge

// ---- tb/jtdr_tester.sv ----
// tester model: drives the test clock and serial data, reads serial out
`timescale 1ns/10ps
module jtdr_tester (
  // bench clock
  input  wire logic clock_in,
  // serial result from the block
  input  wire logic tdo_in,
  // test clock and serial data
  output logic      tck_out,
  output logic      tdi_out
);
  // test clock stands low outside frames
  initial begin
    tck_out = 1'b0;
    tdi_out = 1'b0;
  end
  // data and rising test clock share an edge: both pass the same two flops,
  // so the block sees the data in the same cycle it acts on the edge; high 4 cycles
  task automatic rise(input logic din);
    @(posedge clock_in);
    tdi_out <= din;
    tck_out <= 1'b1;
    repeat (3) @(posedge clock_in);
  endtask : rise
  // falling test clock, low 4 cycles; serial out taken just after it is launched
  task automatic fall(output logic dout);
    @(posedge clock_in);
    tck_out <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 dout = tdo_in;
  endtask : fall
  // released data line toggles so stale values are never trusted
  task automatic park();
    @(posedge clock_in);
    tdi_out <= ~tdi_out;
  endtask : park
endmodule : jtdr_tester

// ---- tb/tb_top.sv ----
// bench: identify, bypass and boundary chain scenarios
`timescale 1ns/10ps
module tb_top;
  localparam logic [3:0]  REV = 4'h5;
  localparam logic [15:0] DEV = 16'h1234; // arbitrary value
  localparam logic [10:0] MFR = 11'h2a5;  // arbitrary value
  localparam logic [31:0] IDW = {REV, DEV, MFR, 1'b1};
  logic                clk, rst_b, tck, tdi, cdat, coe_b, obs, pdat, poe_b, tdo, d;
  logic [31:0]         idl;
  jtdr_pkg::jtdr_ctl_t ctl;
  int                  err_total, checked, cycles;
  jtdr_top #(.REVISION(REV), .DEV_CODE(DEV), .MFR_CODE(MFR)) jtdr_top_inst (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .TEST_CLOCK_PIN_IN(tck), .TEST_SERIAL_IN_IN(tdi),
    .TAP_CTL_IN(ctl), .CORE_DATA_IN(cdat), .CORE_OE_B_IN(coe_b), .PAD_OBS_IN(obs),
    .PAD_DATA_OUT(pdat), .PAD_OE_B_OUT(poe_b), .TEST_SERIAL_OUT_OUT(tdo), .ID_LATCH_OUT(idl));
  jtdr_tester jtdr_tester_inst (.clock_in(clk), .tdo_in(tdo), .tck_out(tck), .tdi_out(tdi));
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // tap state and instruction change between test clock edges
  task automatic setc(input jtdr_pkg::jtdr_state_t st, input logic [2:0] ins);
    @(posedge clk);
    ctl <= '{state: st, instr: ins};
  endtask : setc
  ////////////////////////////////////////////////////////////////////////////
  // id word out lsb first, latch held while shifting, then updated and reforced
  task automatic test_identify();
    logic [31:0] pat;
    pat = 32'hc3a50f96;
    setc(jtdr_pkg::JTDR_CAPTURE, jtdr_pkg::INSTR_IDENTIFY);
    jtdr_tester_inst.rise(1'b0);
    setc(jtdr_pkg::JTDR_SHIFT, jtdr_pkg::INSTR_IDENTIFY);
    for (int i = 0; i < 32; i++) begin
      jtdr_tester_inst.fall(d);
      chk("id serial bit", {31'h0, IDW[i]}, {31'h0, d});
      jtdr_tester_inst.rise(pat[i]);
    end
    chk("id latch while shifting", IDW, idl);
    setc(jtdr_pkg::JTDR_UPDATE, jtdr_pkg::INSTR_IDENTIFY);
    jtdr_tester_inst.fall(d);
    chk("id latch after update", pat, idl);
    setc(jtdr_pkg::JTDR_TLR, jtdr_pkg::INSTR_BYPASS);
    jtdr_tester_inst.rise(1'b0);
    jtdr_tester_inst.fall(d);
    chk("id latch in reset state", IDW, idl);
    jtdr_tester_inst.park();
  endtask : test_identify
  // one-stage path for each bypass-class instruction
  task automatic test_bypass();
    logic [2:0] codes [3];
    codes = '{jtdr_pkg::INSTR_BYPASS, jtdr_pkg::INSTR_CLAMP, jtdr_pkg::INSTR_FLOAT};
    foreach (codes[k]) begin
      setc(jtdr_pkg::JTDR_SHIFT, codes[k]);
      for (int b = 0; b < 3; b++) begin
        jtdr_tester_inst.rise(~b[0]);
        jtdr_tester_inst.fall(d);
        chk("bypass serial bit", {31'h0, ~b[0]}, {31'h0, d});
      end
    end
    chk("id latch untouched", IDW, idl);
    jtdr_tester_inst.park();
  endtask : test_bypass
  // observe cell capture, chain load, then pads under each pad instruction
  task automatic test_boundary();
    logic [2:0] codes [3];
    codes = '{jtdr_pkg::INSTR_EXTERNAL_TEST_INSTRUCTION, jtdr_pkg::INSTR_CLAMP, jtdr_pkg::INSTR_FLOAT};
    setc(jtdr_pkg::JTDR_CAPTURE, jtdr_pkg::INSTR_SAMPLE);
    jtdr_tester_inst.rise(1'b0);
    setc(jtdr_pkg::JTDR_SHIFT, jtdr_pkg::INSTR_SAMPLE);
    jtdr_tester_inst.fall(d);
    chk("control cell", {31'h0, ~coe_b}, {31'h0, d});
    for (int i = 0; i < 3; i++) begin
      jtdr_tester_inst.rise(i < 2);
      if (i == 2) setc(jtdr_pkg::JTDR_UPDATE, jtdr_pkg::INSTR_SAMPLE);
      jtdr_tester_inst.fall(d);
      if (i == 0) chk("output cell", {31'h0, cdat}, {31'h0, d});
      if (i == 1) chk("observe cell", 32'h1, {31'h0, d});
    end
    foreach (codes[k]) begin
      setc(jtdr_pkg::JTDR_SHIFT, codes[k]);
      jtdr_tester_inst.rise(1'b0);
      jtdr_tester_inst.fall(d);
      chk("pad enable", {31'h0, codes[k] == jtdr_pkg::INSTR_FLOAT}, {31'h0, poe_b});
      chk("pad data", {31'h0, codes[k] != jtdr_pkg::INSTR_FLOAT}, {31'h0, pdat});
    end
    setc(jtdr_pkg::JTDR_IDLE, jtdr_pkg::INSTR_BYPASS);
    repeat (6) @(posedge clk);
    chk("normal pads", 32'h1, {30'h0, pdat, poe_b});
    jtdr_tester_inst.park();
  endtask : test_boundary
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("[ERR] run time expected below 20000 seen %0d", cycles);
      summarize();
    end
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    cdat = 1'b0;
    coe_b = 1'b1;
    obs = 1'b1;
    ctl = '{state: jtdr_pkg::JTDR_TLR, instr: jtdr_pkg::INSTR_BYPASS};
    repeat (20) @(posedge clk);
    chk("pad enable in reset", 32'h1, {31'h0, poe_b});
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk("id latch after reset", IDW, idl);
    test_identify();
    test_bypass();
    test_boundary();
    summarize();
  end
endmodule : tb_top
